// [include/psut_map.svh]
// Register offsets, field positions, reset values and counts of the telemetry read-back block.
// Assumes inclusion by bare name from files under core/ and tb/.
`ifndef PSUT_MAP_SVH
`define PSUT_MAP_SVH

// ----------------------------------------------------------------
// Serial access
// ----------------------------------------------------------------
`define PSUT_SLAVE_ADDR   7'h18
`define PSUT_GENCALL      7'h00
`define PSUT_CMD_RDPTR    8'h80
`define PSUT_PTR_RST      8'h14
`define PSUT_BYTE_BITS    4'h8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSUT_OFF_INSTANT  8'h14
`define PSUT_OFF_MODE     8'h16
`define PSUT_OFF_ICUR     8'h18
`define PSUT_OFF_VAVG     8'h1a
`define PSUT_OFF_VDAC     8'h1c
`define PSUT_OFF_DOF      8'h1e
`define PSUT_OFF_ARLO     8'h20
`define PSUT_OFF_INTR     8'h22
`define PSUT_OFF_TON      8'h2a
`define PSUT_OFF_TOFF     8'h2c
`define PSUT_OFF_EOL      8'h2e

// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define PSUT_IB_INTEN     15
`define PSUT_IB_READY     14
`define PSUT_IB_DISCH     13
`define PSUT_IB_LSRDY     12
`define PSUT_IB_CVEN      10
`define PSUT_IB_OTP       9
`define PSUT_IB_V4        5
`define PSUT_IB_V10       4
`define PSUT_IB_ISSC      3
`define PSUT_IB_CCSC      2
`define PSUT_IB_UV        1
`define PSUT_IB_OV        0
`define PSUT_V4_NUM       17'h0001a
`define PSUT_V4_DEN       17'h00019
`define PSUT_V10_NUM      17'h0000b
`define PSUT_V10_DEN      17'h0000a
`define PSUT_DO_MASK      7'h57
`define PSUT_AR_LSB       9
`define PSUT_AR_CVO       5
`define PSUT_AR_VBUS      4
`define PSUT_LO_VBUS      5
`define PSUT_INT_W        9
`define PSUT_INT_MASK_LSB 9
`define PSUT_EOL_SIGN     3
`define PSUT_MODE_CC      3'h4
`define PSUT_MODE_CP      3'h2
`define PSUT_MODE_CV      3'h1
`define PSUT_SAMPLE_LAST  4'hf
`define PSUT_AVG_SHIFT    4

`endif

// [include/psut_pkg.sv]
// Types shared by the telemetry read-back block.
// Assumes nothing of its surroundings.
package psut_pkg;

	// Serial slave states, one-hot.
	typedef enum logic [6:0]
	{
		PSUT_IDLE  = 7'h01,
		PSUT_ADDR  = 7'h02,
		PSUT_ACK_A = 7'h04,
		PSUT_WR    = 7'h08,
		PSUT_ACK_W = 7'h10,
		PSUT_RD    = 7'h20,
		PSUT_ACK_R = 7'h40
	} psut_i2c_e;

	// Whole state of the top module.
	typedef struct packed
	{
		logic        scl_m;
		logic        scl_q;
		logic        scl_p;
		logic        sda_m;
		logic        sda_q;
		logic        sda_p;
		psut_i2c_e   st;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        rw;
		logic        first;
		logic        cmd_ptr;
		logic        hi;
		logic        nack;
		logic        sda_oe;
		logic [7:0]  ptr;
		logic [15:0] hold;
		logic        rd_done;
		logic [15:0] instant;
		logic [2:0]  mode;
		logic        ls_ready;
		logic [3:0]  prot_p;
	} psut_top_s;

endpackage

// [include/psut_rec_if.sv]
// Carrier between the core and one sticky fault record.
// Assumes the core drives events and the clear, the record returns its bits.
`timescale 1ns/100ps
`default_nettype none

interface psut_rec_if #(parameter int W = 8);
	logic [W-1:0] set_evt;
	logic         clr;
	logic [W-1:0] bits;
	modport core (output set_evt, output clr, input bits);
	modport rec (input set_evt, input clr, output bits);
endinterface

`default_nettype wire

// [core/psut_fault_rec.sv]
// Sticky record of fault causes, cleared by a completed host read.
// Assumes events and clear come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none

module psut_fault_rec #(parameter int W = 8)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Record carrier
	psut_rec_if.rec   port
);
	typedef struct packed
	{
		logic [W-1:0] bits;
	} psut_rec_s;

	psut_rec_s r_reg;
	psut_rec_s r_next;

	generate
		if (W < 1 || W > 16)
		begin : g_chk
			$error("psut_fault_rec width out of range");
		end
	endgenerate

	// A new cause arriving with the clear survives it.
	always_comb
	begin
		r_next = r_reg;
		r_next.bits = (r_reg.bits & ~{W{port.clr}}) | port.set_evt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			r_reg <= '0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign port.bits = r_reg.bits;
endmodule

`default_nettype wire

// [core/psut_avg16.sv]
// Accumulates blocks of sixteen samples and holds the last complete sum.
// Assumes sample and strobe come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "psut_map.svh"

module psut_avg16 #(parameter int SW = 8)
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	// Samples
	input  wire logic          smp_valid,
	input  wire logic [SW-1:0] smp,
	// Result
	output logic [SW+3:0]      sum,
	output logic               done
);
	typedef struct packed
	{
		logic [SW+3:0] acc;
		logic [3:0]    cnt;
		logic [SW+3:0] sum;
		logic          done;
	} psut_avg_s;

	psut_avg_s r_reg;
	psut_avg_s r_next;
	logic [SW+3:0] acc_add;

	generate
		if (SW < 1 || SW > 12)
		begin : g_chk
			$error("psut_avg16 sample width out of range");
		end
	endgenerate

	// The sum is only replaced when a full block is in, so readers never see a partial one.
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		acc_add = r_reg.acc + (SW+4)'(smp);
		if (smp_valid)
		begin
			r_next.cnt = r_reg.cnt + 4'h1;
			if (r_reg.cnt == `PSUT_SAMPLE_LAST)
			begin
				r_next.sum = acc_add;
				r_next.acc = '0;
				r_next.done = 1'b1;
			end
			else
			begin
				r_next.acc = acc_add;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			r_reg <= '0;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign sum = r_reg.sum;
	assign done = r_reg.done;
endmodule

`default_nettype wire

// [core/psut_telemetry.sv]
// Telemetry read-back register set with its two-wire serial slave.
// Assumes status inputs, samples and events come from logic on clk_sys; scl and sda come from pins.
//
// Contract
// - Average current is the 16-sample mean in bits 7:0, upper byte zero.
// - Average voltage is the 16-sample mean in bits 11:0, top nibble zero.
// - Primary on-time word is the 12-bit sum of 16 samples, top nibble zero.
// - Rectifier on-time word is the full 16-bit sum of 16 samples.
// - Status bit 12 flags line-sense on-time reports ready to read.
// - Status bits 3, 2 and 9 show sense short, output short, over-temperature now.
// - Status bits 5, 4 comparators; flags for voltage above 1.04 and 1.1 set point.
// - Status bit 10 shows whether a new voltage set point is accepted.
// - Disable-output record: bits 6, 4, 2, 1, 0 hold its causes.
// - Auto-restart record: bits 14 down to 9 hold its causes.
// - Latch-off record: bits 6 down to 0 hold its causes.
// - Latch-off bit 7 marks a latch-off caused by the turn-off command.
// - Calibration word: offset magnitude in bits 2:0, sign in bit 3.
`timescale 1ns/100ps
`default_nettype none
`include "psut_map.svh"

module psut_telemetry
	import psut_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = `PSUT_SLAVE_ADDR
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Serial pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_o,
	output logic             sda_oe,
	// Instantaneous conditions
	input  wire logic        int_enable,
	input  wire logic        sys_ready,
	input  wire logic        output_discharge_flag,
	input  wire logic        voltage_cmd_allowed,
	input  wire logic        otp_fault,
	input  wire logic        sense_pin_short,
	input  wire logic        output_short,
	input  wire logic        output_undervoltage,
	input  wire logic        output_overvoltage,
	input  wire logic [11:0] cv_setpoint,
	// Regulation mode
	input  wire logic        mode_cc,
	input  wire logic        mode_cp,
	// Samples
	input  wire logic        cur_valid,
	input  wire logic [7:0]  cur_sample,
	input  wire logic        volt_valid,
	input  wire logic [11:0] volt_sample,
	input  wire logic        ton_valid,
	input  wire logic [7:0]  ton_sample,
	input  wire logic        toff_valid,
	input  wire logic [11:0] toff_sample,
	// Other read-back values
	input  wire logic [15:0] vdac_value,
	input  wire logic [6:0]  int_mask,
	input  wire logic        eol_cal_sign,
	input  wire logic [2:0]  eol_cal_mag,
	// Fault events
	input  wire logic [6:0]  do_evt,
	input  wire logic [5:0]  ar_evt,
	input  wire logic [7:0]  lo_evt
);
	import psut_pkg::*;

	psut_top_s   r_reg;
	psut_top_s   r_next;
	logic [15:0] rd_word;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	logic        v4_flag;
	logic        v10_flag;
	logic [2:0]  mode_next;
	logic [3:0]  prot_now;
	logic [11:0] cur_sum;
	logic [15:0] volt_sum;
	logic [11:0] ton_sum;
	logic [15:0] toff_sum;
	logic        ton_done;

	psut_rec_if #(.W(7))           do_if();
	psut_rec_if #(.W(14))          arlo_if();
	psut_rec_if #(.W(`PSUT_INT_W)) int_if();

	generate
		if (SLAVE_ADDR == `PSUT_GENCALL)
		begin : g_chk
			$error("psut_telemetry slave address must not be the general call");
		end
	endgenerate

	// True when a finished read of the given word should clear it.
	function automatic logic read_clears(input logic done, input logic [7:0] ptr, input logic [7:0] off);
		read_clears = done && (ptr == off);
	endfunction

	// ----------------------------------------------------------------
	// Sixteen-sample averages and sums
	// ----------------------------------------------------------------
	psut_avg16 #(.SW(8)) u_cur (.clk_sys(clk_sys), .rst_b(rst_b), .smp_valid(cur_valid),
		.smp(cur_sample), .sum(cur_sum), .done());
	psut_avg16 #(.SW(12)) u_volt (.clk_sys(clk_sys), .rst_b(rst_b), .smp_valid(volt_valid),
		.smp(volt_sample), .sum(volt_sum), .done());
	psut_avg16 #(.SW(8)) u_ton (.clk_sys(clk_sys), .rst_b(rst_b), .smp_valid(ton_valid),
		.smp(ton_sample), .sum(ton_sum), .done(ton_done));
	psut_avg16 #(.SW(12)) u_toff (.clk_sys(clk_sys), .rst_b(rst_b), .smp_valid(toff_valid),
		.smp(toff_sample), .sum(toff_sum), .done());

	// ----------------------------------------------------------------
	// Fault records, cleared when the host finishes reading them
	// ----------------------------------------------------------------
	psut_fault_rec #(.W(7))           u_do (.clk_sys(clk_sys), .rst_b(rst_b), .port(do_if.rec));
	psut_fault_rec #(.W(14))          u_arlo (.clk_sys(clk_sys), .rst_b(rst_b), .port(arlo_if.rec));
	psut_fault_rec #(.W(`PSUT_INT_W)) u_int (.clk_sys(clk_sys), .rst_b(rst_b), .port(int_if.rec));

	// Unused disable-output positions are masked so they always read zero.
	assign do_if.set_evt = do_evt & `PSUT_DO_MASK;
	assign do_if.clr = read_clears(r_reg.rd_done, r_reg.ptr, `PSUT_OFF_DOF);
	assign arlo_if.set_evt = {ar_evt, lo_evt};
	assign arlo_if.clr = read_clears(r_reg.rd_done, r_reg.ptr, `PSUT_OFF_ARLO);
	assign int_if.clr = read_clears(r_reg.rd_done, r_reg.ptr, `PSUT_OFF_INTR);

	// Interrupt sources: protection edges, fault records, readiness and mode changes.
	assign prot_now = {sense_pin_short, output_short, output_undervoltage, output_overvoltage};
	assign int_if.set_evt = {
		mode_next != r_reg.mode,
		ar_evt[`PSUT_AR_VBUS] | lo_evt[`PSUT_LO_VBUS],
		~sys_ready,
		|lo_evt,
		ar_evt[`PSUT_AR_CVO],
		prot_now & ~r_reg.prot_p};

	// ----------------------------------------------------------------
	// Instantaneous flags
	// ----------------------------------------------------------------
	// Products stay within 17 bits, so no ratio is rounded.
	assign v4_flag = (17'(volt_sample) * `PSUT_V4_DEN) > (17'(cv_setpoint) * `PSUT_V4_NUM);
	assign v10_flag = (17'(volt_sample) * `PSUT_V10_DEN) > (17'(cv_setpoint) * `PSUT_V10_NUM);

	// Only one mode flag may be active; current limit outranks power limit.
	assign mode_next = mode_cc ? `PSUT_MODE_CC : (mode_cp ? `PSUT_MODE_CP : `PSUT_MODE_CV);

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	// Unmapped pointers read as zero.
	always_comb
	begin
		case (r_reg.ptr)
			`PSUT_OFF_INSTANT: rd_word = r_reg.instant;
			`PSUT_OFF_MODE:    rd_word = 16'(r_reg.mode);
			`PSUT_OFF_ICUR:    rd_word = 16'(cur_sum[11:`PSUT_AVG_SHIFT]);
			`PSUT_OFF_VAVG:    rd_word = 16'(volt_sum[15:`PSUT_AVG_SHIFT]);
			`PSUT_OFF_VDAC:    rd_word = vdac_value;
			`PSUT_OFF_DOF:     rd_word = 16'(do_if.bits);
			`PSUT_OFF_ARLO:    rd_word = 16'(arlo_if.bits[7:0]) | (16'(arlo_if.bits[13:8]) << `PSUT_AR_LSB);
			`PSUT_OFF_INTR:    rd_word = 16'(int_if.bits) | (16'(int_mask) << `PSUT_INT_MASK_LSB);
			`PSUT_OFF_TON:     rd_word = 16'(ton_sum);
			`PSUT_OFF_TOFF:    rd_word = toff_sum;
			`PSUT_OFF_EOL:     rd_word = 16'(eol_cal_mag) | (16'(eol_cal_sign) << `PSUT_EOL_SIGN);
			default:           rd_word = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Serial slave and register state
	// ----------------------------------------------------------------
	// Edges are judged from the second and third flops only; the first flop is a synchroniser.
	assign rise = r_reg.scl_q & ~r_reg.scl_p;
	assign fall = ~r_reg.scl_q & r_reg.scl_p;
	assign start = r_reg.scl_q & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_q;
	assign stop = r_reg.scl_q & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_q;

	always_comb
	begin
		r_next = r_reg;
		r_next.scl_m = scl_in;
		r_next.scl_q = r_reg.scl_m;
		r_next.scl_p = r_reg.scl_q;
		r_next.sda_m = sda_in;
		r_next.sda_q = r_reg.sda_m;
		r_next.sda_p = r_reg.sda_q;
		r_next.rd_done = 1'b0;
		r_next.mode = mode_next;
		r_next.prot_p = prot_now;
		// A block that completes in the clearing cycle still raises the flag.
		r_next.ls_ready = (r_reg.ls_ready & ~read_clears(r_reg.rd_done, r_reg.ptr, `PSUT_OFF_TON))
			| ton_done;
		r_next.instant = 16'h0000;
		r_next.instant[`PSUT_IB_INTEN] = int_enable;
		r_next.instant[`PSUT_IB_READY] = sys_ready;
		r_next.instant[`PSUT_IB_DISCH] = output_discharge_flag;
		r_next.instant[`PSUT_IB_LSRDY] = r_next.ls_ready;
		r_next.instant[`PSUT_IB_CVEN] = voltage_cmd_allowed;
		r_next.instant[`PSUT_IB_OTP] = otp_fault;
		r_next.instant[`PSUT_IB_V4] = v4_flag;
		r_next.instant[`PSUT_IB_V10] = v10_flag;
		r_next.instant[`PSUT_IB_ISSC] = sense_pin_short;
		r_next.instant[`PSUT_IB_CCSC] = output_short;
		r_next.instant[`PSUT_IB_UV] = output_undervoltage;
		r_next.instant[`PSUT_IB_OV] = output_overvoltage;
		if (start)
		begin
			r_next.st = PSUT_ADDR;
			r_next.bitcnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			r_next.st = PSUT_IDLE;
			r_next.sda_oe = 1'b0;
		end
		else
		begin
			case (r_reg.st)
				PSUT_ADDR, PSUT_WR:
				begin
					if (rise)
					begin
						r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_q};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end
					else if (fall && r_reg.bitcnt == `PSUT_BYTE_BITS)
					begin
						if (r_reg.st == PSUT_WR)
						begin
							r_next.sda_oe = 1'b1;
							r_next.st = PSUT_ACK_W;
							r_next.first = 1'b0;
							if (r_reg.first)
							begin
								r_next.cmd_ptr = (r_reg.shreg == `PSUT_CMD_RDPTR);
							end
							else if (r_reg.cmd_ptr)
							begin
								r_next.ptr = r_reg.shreg;
							end
						end
						else if (r_reg.shreg[7:1] == SLAVE_ADDR)
						begin
							r_next.rw = r_reg.shreg[0];
							r_next.sda_oe = 1'b1;
							r_next.st = PSUT_ACK_A;
						end
						else
						begin
							r_next.st = PSUT_IDLE;
						end
					end
				end
				PSUT_ACK_A:
				begin
					if (fall)
					begin
						r_next.bitcnt = 4'h0;
						if (r_reg.rw)
						begin
							r_next.shreg = rd_word[7:0];
							r_next.hold = rd_word;
							r_next.hi = 1'b1;
							r_next.sda_oe = ~rd_word[7];
							r_next.st = PSUT_RD;
						end
						else
						begin
							r_next.sda_oe = 1'b0;
							r_next.first = 1'b1;
							r_next.st = PSUT_WR;
						end
					end
				end
				PSUT_ACK_W:
				begin
					if (fall)
					begin
						r_next.sda_oe = 1'b0;
						r_next.bitcnt = 4'h0;
						r_next.st = PSUT_WR;
					end
				end
				PSUT_RD:
				begin
					if (rise)
					begin
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end
					else if (fall)
					begin
						if (r_reg.bitcnt == `PSUT_BYTE_BITS)
						begin
							r_next.sda_oe = 1'b0;
							r_next.st = PSUT_ACK_R;
						end
						else
						begin
							r_next.shreg = {r_reg.shreg[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shreg[6];
						end
					end
				end
				PSUT_ACK_R:
				begin
					if (rise)
					begin
						r_next.nack = r_reg.sda_q;
					end
					else if (fall)
					begin
						r_next.bitcnt = 4'h0;
						r_next.rd_done = ~r_reg.hi;
						if (r_reg.nack)
						begin
							r_next.st = PSUT_IDLE;
						end
						else if (r_reg.hi)
						begin
							// The high byte comes from the held copy so a word never tears.
							r_next.shreg = r_reg.hold[15:8];
							r_next.sda_oe = ~r_reg.hold[15];
							r_next.hi = 1'b0;
							r_next.st = PSUT_RD;
						end
						else
						begin
							r_next.shreg = rd_word[7:0];
							r_next.hold = rd_word;
							r_next.hi = 1'b1;
							r_next.sda_oe = ~rd_word[7];
							r_next.st = PSUT_RD;
						end
					end
				end
				PSUT_IDLE:
				begin
					r_next.sda_oe = 1'b0;
				end
				default:
				begin
					r_next.st = PSUT_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Idle pins are high, so the edge flops reset high to avoid a false start.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			r_reg <= '0;
			r_reg.scl_m <= 1'b1;
			r_reg.scl_q <= 1'b1;
			r_reg.scl_p <= 1'b1;
			r_reg.sda_m <= 1'b1;
			r_reg.sda_q <= 1'b1;
			r_reg.sda_p <= 1'b1;
			r_reg.st <= PSUT_IDLE;
			r_reg.ptr <= `PSUT_PTR_RST;
			r_reg.mode <= `PSUT_MODE_CV;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// Open-drain: the pin only ever pulls low.
	assign sda_o = 1'b0;
	assign sda_oe = r_reg.sda_oe;
endmodule

`default_nettype wire

// [tb/psut_sva.sv]
// Concurrent checks on the serial pins.
// Assumes it is bound to psut_telemetry and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module psut_sva
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_o,
	input wire logic sda_oe
);
	logic [7:0] scl_hi_reg;
	logic [7:0] oe_run_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Saturating run lengths of scl high and of sda pulled.
	always_ff @(posedge clk_sys)
	begin
		scl_hi_reg <= (!rst_b || !scl_in) ? 8'h00 : scl_hi_reg + {7'h00, scl_hi_reg != 8'hff};
		oe_run_reg <= (!rst_b || !sda_oe) ? 8'h00 : oe_run_reg + {7'h00, oe_run_reg != 8'hff};
	end

	// Open drain: only the enable moves the pin.
	property p_od_low;
		sda_o == 1'b0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("sda_o not low");

	// Reset releases the wire on the next edge.
	property p_rst_quiet;
		disable iff (1'b0) !rst_b |=> !sda_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("sda held in reset");

	// The wire stays free for four cycles after release.
	property p_wake_quiet;
		$rose(rst_b) |-> !sda_oe [*4];
	endproperty
	a_wake_quiet: assert property (p_wake_quiet) else $error("sda driven after reset");

	// Enable edges follow an scl fall, never under scl high.
	property p_oe_rise;
		$rose(sda_oe) |-> !$past(scl_in, 2);
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("sda pulled outside scl low");

	property p_oe_fall;
		$fell(sda_oe) |-> !$past(scl_in, 2);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("sda released outside scl low");

	property p_hold_high;
		scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3) |-> $stable(sda_oe);
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("sda moved while scl high");

	// A long scl high is an idle bus; sda must be free.
	property p_idle_free;
		scl_hi_reg == 8'h10 |-> !sda_oe;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("sda held on idle bus");

	// Nine bits at the slowest bench rate fit under this.
	property p_oe_bound;
		oe_run_reg < 8'h90;
	endproperty
	a_oe_bound: assert property (p_oe_bound) else $error("sda held too long");
endmodule

`default_nettype wire

// [tb/psut_host_model.sv]
// Two-wire host model that reads telemetry words.
// Assumes a pulled-up wire: the AND of this driver and the device.
`timescale 1ns/100ps
`default_nettype none
`include "psut_map.svh"

module psut_host_model
(
	// Clock
	input  wire logic clk_sys,
	// Bus
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_wire
);
	// Half scl period in clk_sys cycles.
	int half = 4;

	// Both lines idle high.
	initial {scl, sda_drv} = 2'h3;

	// Changes land just after a clock edge.
	task automatic wt();
		repeat (half) @(posedge clk_sys);
		#1;
	endtask

	// Start: sda falls while scl is high.
	task automatic start();
		sda_drv = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_drv = 1'b0;
		wt();
		scl = 1'b0;
	endtask

	// Stop: sda rises while scl is high.
	task automatic stop();
		sda_drv = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_drv = 1'b1;
		wt();
	endtask

	// Eight bits and an ack; the wire is sampled before scl falls.
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		logic [8:0] o;
		for (int i = 8; i >= 0; i--)
		begin
			sda_drv = (i == 0) ? ai : d[i - 1];
			wt();
			scl = 1'b1;
			wt();
			o[i] = sda_wire;
			scl = 1'b0;
		end
		{q, ao} = o;
	endtask

	// Pointer write, repeated start, low then high byte, nack.
	task automatic read_word(input logic [7:0] ptr, output logic [15:0] w, output logic ok);
		logic [7:0] q;
		logic [4:0] a;
		start();
		xfer({`PSUT_SLAVE_ADDR, 1'b0}, 1'b1, q, a[0]);
		xfer(`PSUT_CMD_RDPTR, 1'b1, q, a[1]);
		xfer(ptr, 1'b1, q, a[2]);
		start();
		xfer({`PSUT_SLAVE_ADDR, 1'b1}, 1'b1, q, a[3]);
		xfer(8'hff, 1'b0, w[7:0], a[4]);
		xfer(8'hff, 1'b1, w[15:8], a[4]);
		stop();
		ok = (a[3:0] == 4'h0);
	endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench: drives the inputs, reads words back serially.
// Assumes the checker and host model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "psut_map.svh"

module tb;
	logic        clk_sys, rst_b, scl_in, sda_in, sda_o, sda_oe, sda_h, int_enable, sys_ready, a;
	logic        output_discharge_flag, voltage_cmd_allowed, otp_fault, sense_pin_short, output_short;
	logic        output_undervoltage, output_overvoltage, mode_cc, mode_cp, cur_valid, volt_valid;
	logic        ton_valid, toff_valid, eol_cal_sign;
	logic [11:0] cv_setpoint, volt_sample, toff_sample;
	logic [7:0]  cur_sample, ton_sample, lo_evt, b;
	logic [15:0] vdac_value, w, ex;
	logic [6:0]  int_mask, do_evt;
	logic [5:0]  ar_evt;
	logic [2:0]  eol_cal_mag;
	integer      seed = 66548;
	int          err_total = 0, compares = 0;
	int          s_c, s_v, s_t, s_f;

	// Pulled-up wire, low when either side pulls it.
	assign sda_in = sda_h & ~sda_oe;

	psut_telemetry u_psut_telemetry
	(
		.clk_sys, .rst_b, .scl_in, .sda_in, .sda_o, .sda_oe, .int_enable, .sys_ready,
		.output_discharge_flag, .voltage_cmd_allowed, .otp_fault, .sense_pin_short, .output_short,
		.output_undervoltage, .output_overvoltage, .cv_setpoint, .mode_cc, .mode_cp, .cur_valid,
		.cur_sample, .volt_valid, .volt_sample, .ton_valid, .ton_sample, .toff_valid, .toff_sample,
		.vdac_value, .int_mask, .eol_cal_sign, .eol_cal_mag, .do_evt, .ar_evt, .lo_evt
	);
	psut_host_model u_psut_host_model (.clk_sys, .scl(scl_in), .sda_drv(sda_h), .sda_wire(sda_in));

	// 125 MHz system clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Serial read of one word, then its check.
	task automatic rchk(input string what, input logic [7:0] p, input logic [15:0] exp);
		logic [15:0] v;
		logic        ok;
		u_psut_host_model.read_word(p, v, ok);
		chk("ack", {15'h0000, ok}, 16'h0001);
		chk(what, v, exp);
	endtask

	// Expected status word; ratio flags are strict.
	function automatic logic [15:0] exp_inst(input logic ls);
		return {int_enable, sys_ready, output_discharge_flag, ls, 1'b0, voltage_cmd_allowed, otp_fault,
			3'h0, volt_sample * 25 > cv_setpoint * 26, volt_sample * 10 > cv_setpoint * 11,
			sense_pin_short, output_short, output_undervoltage, output_overvoltage};
	endfunction

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected 20k cycles.
	initial
	begin
		#600000;
		err_total++;
		give_verdict();
	end

	// Main sequence.
	initial
	begin
		{int_enable, output_discharge_flag, voltage_cmd_allowed, otp_fault, sense_pin_short, output_short,
			output_undervoltage, output_overvoltage, mode_cc, mode_cp, cur_valid, volt_valid, ton_valid,
			toff_valid, eol_cal_sign, rst_b} = '0;
		{cv_setpoint, volt_sample, toff_sample, cur_sample, ton_sample, lo_evt, vdac_value, int_mask,
			do_evt, ar_evt, eol_cal_mag} = '0;
		sys_ready = 1'b1;
		tick(10);
		rst_b = 1'b1;
		tick(4);
		rchk("ready", `PSUT_OFF_INSTANT, exp_inst(1'b0));
		u_psut_host_model.start();
		u_psut_host_model.xfer(8'h40, 1'b1, b, a);
		u_psut_host_model.stop();
		chk("nack", {15'h0000, a}, 16'h0001);
		for (int i = 0; i < 4; i++)
		begin
			{mode_cc, mode_cp} = 2'(i);
			tick(2);
			rchk("mode", `PSUT_OFF_MODE, i[1] ? 16'h0004 : (i[0] ? 16'h0002 : 16'h0001));
		end
		// Block 0 full scale, block 1 random.
		for (int k = 0; k < 2; k++)
		begin
			{s_c, s_v, s_t, s_f} = '0;
			repeat (16)
			begin
				cur_sample = k ? 8'($random(seed)) : 8'hff;
				volt_sample = k ? 12'($random(seed)) : 12'hfff;
				ton_sample = k ? 8'($random(seed)) : 8'hff;
				toff_sample = k ? 12'($random(seed)) : 12'hfff;
				{s_c, s_v, s_t, s_f} = {s_c + cur_sample, s_v + volt_sample, s_t + ton_sample, s_f + toff_sample};
				{cur_valid, volt_valid, ton_valid, toff_valid} = 4'hf;
				tick(1);
				{cur_valid, volt_valid, ton_valid, toff_valid} = 4'h0;
				tick(1);
			end
			tick(2);
			rchk("ls_ready", `PSUT_OFF_INSTANT, exp_inst(1'b1));
			rchk("i_avg", `PSUT_OFF_ICUR, {8'h00, 8'(s_c >> 4)});
			rchk("v_avg", `PSUT_OFF_VAVG, {4'h0, 12'(s_v >> 4)});
			rchk("ton", `PSUT_OFF_TON, {4'h0, 12'(s_t)});
			rchk("toff", `PSUT_OFF_TOFF, 16'(s_f));
			rchk("ls_clear", `PSUT_OFF_INSTANT, exp_inst(1'b0));
		end
		// Passes 0 and 1 straddle the 1.04 threshold.
		for (int i = 0; i < 6; i++)
		begin
			{int_enable, sys_ready, output_discharge_flag, voltage_cmd_allowed, otp_fault, sense_pin_short,
				output_short, output_undervoltage, output_overvoltage, eol_cal_sign, eol_cal_mag} = 13'($random(seed));
			vdac_value = 16'($random(seed));
			cv_setpoint = (i < 2) ? 12'h019 : 12'($random(seed));
			volt_sample = (i < 2) ? 12'h01a + 12'(i) : 12'($random(seed));
			volt_valid = 1'b1;
			tick(1);
			volt_valid = 1'b0;
			tick(2);
			rchk("instant", `PSUT_OFF_INSTANT, exp_inst(1'b0));
			rchk("vdac", `PSUT_OFF_VDAC, vdac_value);
			rchk("eol", `PSUT_OFF_EOL, {12'h000, eol_cal_sign, eol_cal_mag});
		end
		for (int i = 0; i < 3; i++)
		begin
			{do_evt, ar_evt, lo_evt} = (i == 0) ? 21'h1fffff : 21'($random(seed));
			w = {9'h000, do_evt & 7'h57};
			ex = {1'b0, ar_evt, 1'b0, lo_evt};
			tick(1);
			{do_evt, ar_evt, lo_evt} = '0;
			tick(1);
			rchk("dis_rec", `PSUT_OFF_DOF, w);
			rchk("arlo_rec", `PSUT_OFF_ARLO, ex);
		end
		// Clear interrupts, then raise five causes.
		{sys_ready, sense_pin_short, output_short, output_undervoltage, output_overvoltage} = 5'h10;
		tick(2);
		u_psut_host_model.read_word(`PSUT_OFF_INTR, w, a);
		int_mask = 7'($random(seed));
		{sense_pin_short, output_overvoltage, ar_evt[5], lo_evt[5]} = 4'hf;
		tick(1);
		{ar_evt[5], lo_evt[5]} = 2'h0;
		tick(2);
		rchk("irq", `PSUT_OFF_INTR, {int_mask, 9'h0b9});
		rchk("irq_clr", `PSUT_OFF_INTR, {int_mask, 9'h000});
		u_psut_host_model.half = 6;
		rchk("unmapped", 8'h24, 16'h0000);
		u_psut_host_model.half = 4;
		give_verdict();
	end
endmodule

bind psut_telemetry psut_sva u_psut_sva (.clk_sys, .rst_b, .scl_in, .sda_o, .sda_oe);

`default_nettype wire
